// ---- logic/fpec_pkg.sv ----
package fpec_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] CTRL_OFS  = 4'h0;
   localparam logic [3:0] PROT_OFS  = 4'h4;
   localparam logic [3:0] ARRAY_OFS = 4'h8;
   localparam logic [3:0] STAT_OFS  = 4'hc;

   // control field positions and reset value
   localparam int         PGM_BIT    = 0;
   localparam int         ERASE_BIT  = 1;
   localparam int         MASS_BIT   = 2;
   localparam int         HV_BIT     = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // array write word fields
   localparam int ADDR_LSB = 0;
   localparam int DATA_LSB = 16;

   // status field positions
   localparam int ST_CHECKED = 0;
   localparam int ST_LATCHED = 1;
   localparam int ST_SETUP   = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_READY   = 4;
   localparam int ST_BLOCKED = 5;

   // ------------------------------------------------------------
   // array geometry and protection
   // ------------------------------------------------------------
   localparam logic [7:0]  ALL_ONES    = 8'hff;
   localparam logic [1:0]  PROT_TOP    = 2'h3;
   localparam logic [5:0]  PROT_LOW    = 6'h00;
   localparam logic [15:0] USER_LO     = 16'hee00;
   localparam logic [15:0] USER_HI     = 16'hfdff;
   localparam logic [15:0] VEC_LO      = 16'hffd0;
   localparam logic [15:0] VEC_HI      = 16'hffff;
   localparam logic [15:0] PROT_ADDR   = 16'hffbe;
   localparam int          ROW_LSB     = 5;
   localparam int          PAGE_LSB    = 6;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 100;
   localparam int SETUP_DELAY_NS  = 10000;
   localparam int READ_RECOVER_NS = 1000;
   localparam int SETUP_CYCLES    = (SETUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_CYCLES  = (READ_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      FPEC_IDLE,
      FPEC_SELECTED,
      FPEC_CHECKED,
      FPEC_LATCHED,
      FPEC_HIGH_V
   } fpec_step_type;

endpackage : fpec_pkg

// ---- logic/fpec_timer.sv ----
`timescale 1ns/10ps
module fpec_timer #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             load_in,
   input  wire logic [WIDTH-1:0] count_in,
   output logic                  done_out
);

   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;

   assign cnt_d    = load_in ? count_in : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
   assign done_out = (cnt_q == '0);

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule : fpec_timer

// ---- logic/fpec_protect.sv ----
`timescale 1ns/10ps
module fpec_protect (
   input  wire logic [7:0]  protect_start_byte_in,
   input  wire logic [15:0] target_addr_in,
   input  wire logic        whole_erase_in,
   output logic [15:0]      start_addr_out,
   output logic             blocked_out
);

   logic open_all;

   // start address built from the protect byte
   assign start_addr_out = {fpec_pkg::PROT_TOP, protect_start_byte_in, fpec_pkg::PROT_LOW};
   // all ones opens everything; all zeros gives a start below the array
   assign open_all       = (protect_start_byte_in == fpec_pkg::ALL_ONES);
   // the protect byte itself sits inside any protected range
   assign blocked_out    = !open_all && (whole_erase_in || (target_addr_in >= start_addr_out));

endmodule : fpec_protect

// ---- logic/fpec_control.sv ----
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module fpec_control #(
   parameter int TIMER_WIDTH = 8
) (
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic [7:0]  protect_start_byte_in,
   output logic             pump_on_out,
   output logic             hv_array_out,
   output logic             program_mode_out,
   output logic             erase_mode_out,
   output logic             mass_mode_out,
   output logic [15:0]      erase_base_out,
   output logic             array_wr_out,
   output logic [15:0]      array_addr_out,
   output logic [7:0]       array_data_out,
   output logic             read_ready_out
);

   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   if ((TIMER_WIDTH < $clog2(fpec_pkg::SETUP_CYCLES + 1)) || (TIMER_WIDTH > 16)) begin : g_bad_width
      $error("timer width cannot hold the setup count");
   end

   localparam logic [TIMER_WIDTH-1:0] SETUP_LOAD   = TIMER_WIDTH'(fpec_pkg::SETUP_CYCLES);
   localparam logic [TIMER_WIDTH-1:0] RECOVER_LOAD = TIMER_WIDTH'(fpec_pkg::RECOVER_CYCLES);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   fpec_pkg::fpec_step_type step_q;
   fpec_pkg::fpec_step_type step_d;
   logic        wait_q;
   logic [31:0] rdata_q;
   logic        pgm_q;
   logic        erase_q;
   logic        mass_q;
   logic        hv_q;
   logic        refused_q;
   logic [15:0] lat_addr_q;
   logic [7:0]  lat_data_q;
   logic        wr_pulse_q;
   logic        ready_q;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   wire        req       = avs_read_in || avs_write_in;
   wire        take      = req && !wait_q;
   wire        sel_ctrl  = (avs_address_in == fpec_pkg::CTRL_OFS);
   wire        sel_prot  = (avs_address_in == fpec_pkg::PROT_OFS);
   wire        sel_array = (avs_address_in == fpec_pkg::ARRAY_OFS);
   wire        sel_stat  = (avs_address_in == fpec_pkg::STAT_OFS);
   wire        wr_ctrl   = take && avs_write_in && sel_ctrl && avs_byteenable_in[0];
   wire        rd_prot   = take && avs_read_in && sel_prot;
   wire        wr_stat   = take && avs_write_in && sel_stat && avs_byteenable_in[0];
   wire        wr_array  = take && avs_write_in && sel_array && (&avs_byteenable_in[2:0]);
   wire [15:0] wr_addr   = avs_writedata_in[fpec_pkg::ADDR_LSB +: 16];
   wire [7:0]  wr_data   = avs_writedata_in[fpec_pkg::DATA_LSB +: 8];

   // only real array cells take part in a sequence
   wire in_user  = (wr_addr >= fpec_pkg::USER_LO) && (wr_addr <= fpec_pkg::USER_HI);
   wire in_vec   = (wr_addr >= fpec_pkg::VEC_LO) && (wr_addr <= fpec_pkg::VEC_HI);
   wire is_prot  = (wr_addr == fpec_pkg::PROT_ADDR);
   wire addr_ok  = in_user || in_vec || is_prot;

   // ------------------------------------------------------------
   // control register write
   // ------------------------------------------------------------
   wire want_p   = avs_writedata_in[fpec_pkg::PGM_BIT];
   wire want_e   = avs_writedata_in[fpec_pkg::ERASE_BIT];
   wire want_m   = avs_writedata_in[fpec_pkg::MASS_BIT];
   wire want_hv  = avs_writedata_in[fpec_pkg::HV_BIT];
   // a write asking for both selects keeps the old ones untouched
   wire conflict = want_p && want_e;
   wire pgm_n    = conflict ? pgm_q : want_p;
   wire erase_n  = conflict ? erase_q : want_e;
   wire sel_n    = pgm_n || erase_n;

   // protection against the latched target of the pending operation
   logic [15:0] start_addr;
   logic        blocked;

   fpec_protect u_protect (
      .protect_start_byte_in (protect_start_byte_in),
      .target_addr_in        (lat_addr_q),
      .whole_erase_in        (erase_n && want_m),
      .start_addr_out        (start_addr),
      .blocked_out           (blocked)
   );

   logic setup_done;
   logic recover_done;

   // high voltage only after the full preparation and outside protection
   wire latched_ok = (step_q == fpec_pkg::FPEC_LATCHED) && setup_done && sel_n;
   wire hv_ok      = hv_q || (latched_ok && !blocked);
   wire hv_n       = want_hv && hv_ok;
   wire refuse_evt = wr_ctrl && ((want_hv && !hv_ok) || conflict);
   wire hv_falls   = wr_ctrl && hv_q && !hv_n;
   wire any_sel    = pgm_q || erase_q;

   // ------------------------------------------------------------
   // array write handling
   // ------------------------------------------------------------
   // first write after the protect read fixes the target
   wire first_wr   = wr_array && addr_ok && (step_q == fpec_pkg::FPEC_CHECKED);
   // later bytes must stay in the latched row, one row per cycle
   wire same_row   = (wr_addr[15:fpec_pkg::ROW_LSB] == lat_addr_q[15:fpec_pkg::ROW_LSB]);
   wire prog_wr    = wr_array && addr_ok && same_row && pgm_q && hv_q
                     && (step_q == fpec_pkg::FPEC_HIGH_V);
   wire fwd_wr     = first_wr || prog_wr;

   fpec_timer #(
      .WIDTH (TIMER_WIDTH)
   ) u_setup_timer (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .load_in    (first_wr),
      .count_in   (SETUP_LOAD),
      .done_out   (setup_done)
   );

   // recovery restarts whenever high voltage is dropped
   fpec_timer #(
      .WIDTH (TIMER_WIDTH)
   ) u_recover_timer (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .load_in    (hv_falls),
      .count_in   (RECOVER_LOAD),
      .done_out   (recover_done)
   );

   // ------------------------------------------------------------
   // sequence tracking
   // ------------------------------------------------------------
   always_comb begin
      step_d = step_q;
      if (!any_sel && !hv_q) begin
         step_d = fpec_pkg::FPEC_IDLE;
      end else begin
         unique case (step_q)
            fpec_pkg::FPEC_IDLE: begin
               step_d = fpec_pkg::FPEC_SELECTED;
            end
            fpec_pkg::FPEC_SELECTED: begin
               if (rd_prot) begin
                  step_d = fpec_pkg::FPEC_CHECKED;
               end
            end
            fpec_pkg::FPEC_CHECKED: begin
               if (first_wr) begin
                  step_d = fpec_pkg::FPEC_LATCHED;
               end
            end
            fpec_pkg::FPEC_LATCHED: begin
               if (hv_q) begin
                  step_d = fpec_pkg::FPEC_HIGH_V;
               end
            end
            fpec_pkg::FPEC_HIGH_V: begin
               if (!hv_q) begin
                  step_d = fpec_pkg::FPEC_IDLE;
               end
            end
            default: begin
               step_d = fpec_pkg::FPEC_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   wire [31:0] ctrl_word = {28'h0000000, hv_q, mass_q, erase_q, pgm_q};
   wire [31:0] prot_word = {24'h000000, protect_start_byte_in};
   wire [31:0] arr_word  = {8'h00, lat_data_q, lat_addr_q};
   wire [31:0] stat_word = {26'h0, blocked, ready_q, refused_q,
                            setup_done && (step_q == fpec_pkg::FPEC_LATCHED),
                            (step_q == fpec_pkg::FPEC_LATCHED) || (step_q == fpec_pkg::FPEC_HIGH_V),
                            (step_q != fpec_pkg::FPEC_IDLE) && (step_q != fpec_pkg::FPEC_SELECTED)};
   // unmapped addresses read as zero and ignore writes
   wire [31:0] rd_mux    = sel_ctrl  ? ctrl_word :
                           sel_prot  ? prot_word :
                           sel_array ? arr_word  :
                           sel_stat  ? stat_word : 32'h00000000;

   // set wins over a write-one clear in the same cycle
   wire clr_refused = wr_stat && avs_writedata_in[fpec_pkg::ST_REFUSED];
   wire refused_d   = refuse_evt || (refused_q && !clr_refused);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // one wait cycle per access; read data is loaded before the accept edge
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h00000000;
      end else begin
         wait_q  <= !(req && wait_q);
         if (avs_read_in && wait_q) begin
            rdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pgm_q   <= fpec_pkg::CTRL_RESET[fpec_pkg::PGM_BIT];
         erase_q <= fpec_pkg::CTRL_RESET[fpec_pkg::ERASE_BIT];
         mass_q  <= fpec_pkg::CTRL_RESET[fpec_pkg::MASS_BIT];
         hv_q    <= fpec_pkg::CTRL_RESET[fpec_pkg::HV_BIT];
      end else if (wr_ctrl) begin
         pgm_q   <= pgm_n;
         erase_q <= erase_n;
         mass_q  <= want_m;
         hv_q    <= hv_n;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         step_q     <= fpec_pkg::FPEC_IDLE;
         refused_q  <= 1'b0;
         lat_addr_q <= 16'h0000;
         lat_data_q <= 8'h00;
         wr_pulse_q <= 1'b0;
         ready_q    <= 1'b1;
      end else begin
         step_q     <= step_d;
         refused_q  <= refused_d;
         wr_pulse_q <= fwd_wr;
         ready_q    <= recover_done && !hv_q && !hv_falls;
         if (fwd_wr) begin
            lat_addr_q <= wr_addr;
            lat_data_q <= wr_data;
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign avs_readdata_out    = rdata_q;
   assign avs_waitrequest_out = wait_q;
   assign pump_on_out         = hv_q;
   assign hv_array_out        = hv_q;
   assign program_mode_out    = pgm_q;
   assign erase_mode_out      = erase_q;
   assign mass_mode_out       = mass_q;
   // the vector area lies wholly inside one aligned page
   assign erase_base_out      = {lat_addr_q[15:fpec_pkg::PAGE_LSB], 6'h00};
   assign array_wr_out        = wr_pulse_q;
   assign array_addr_out      = lat_addr_q;
   assign array_data_out      = lat_data_q;
   assign read_ready_out      = ready_q;

endmodule : fpec_control

// ---- tb/fpec_control_props.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker for the flash control block
// ------------------------------------------------------------
module fpec_control_props #(
   parameter int TIMER_WIDTH = 8
) (
   input wire logic        clk_in,
   input wire logic        reset_n_in,
   input wire logic [3:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic [7:0]  protect_start_byte_in,
   input wire logic        pump_on_out,
   input wire logic        hv_array_out,
   input wire logic        program_mode_out,
   input wire logic        erase_mode_out,
   input wire logic        mass_mode_out,
   input wire logic [15:0] erase_base_out,
   input wire logic        array_wr_out,
   input wire logic [15:0] array_addr_out,
   input wire logic [7:0]  array_data_out,
   input wire logic        read_ready_out
);
   default clocking mon_cb @(posedge clk_in);
   endclocking
   default disable iff (!reset_n_in);

   AST_PUMP_TIE: assert property (pump_on_out == hv_array_out)
      else $error("pump and array voltage differ");
   AST_SEL_EXCL: assert property (!(program_mode_out && erase_mode_out))
      else $error("program and erase selected together");
   AST_HV_SELECT: assert property ($rose(hv_array_out) |-> program_mode_out || erase_mode_out)
      else $error("voltage raised with no select");
   AST_HV_BY_WRITE: assert property ($rose(hv_array_out) |-> $past(avs_write_in && !avs_waitrequest_out
      && avs_address_in == fpec_pkg::CTRL_OFS && avs_writedata_in[fpec_pkg::HV_BIT]))
      else $error("voltage raised without a control write");
   AST_MASS_LOCK: assert property ($rose(hv_array_out) && mass_mode_out
      |-> $past(protect_start_byte_in) == fpec_pkg::ALL_ONES)
      else $error("whole erase started while protected");
   AST_HV_PROTECT: assert property ($rose(hv_array_out) && !mass_mode_out
      |-> $past(protect_start_byte_in) == fpec_pkg::ALL_ONES
      || erase_base_out < {fpec_pkg::PROT_TOP, $past(protect_start_byte_in), fpec_pkg::PROT_LOW})
      else $error("voltage raised on a protected target");
   AST_BASE_ALIGN: assert property (erase_base_out[5:0] == 6'h00)
      else $error("target base not page aligned");
   AST_ROW_FWD: assert property (array_wr_out && hv_array_out
      |-> array_addr_out[15:5] == $past(array_addr_out[15:5]))
      else $error("forwarded write outside the latched row");
   AST_WR_PULSE: assert property (array_wr_out |=> !array_wr_out)
      else $error("array write strobe longer than one cycle");
   // reads stay parked for 7 cycles starting two cycles after the drop, then come back in bounded time
   AST_READY_RECOVER: assert property ($fell(hv_array_out)
      |-> ##2 !read_ready_out [*7] ##[1:6] read_ready_out)
      else $error("read recovery span wrong");
endmodule : fpec_control_props

bind fpec_control fpec_control_props #(.TIMER_WIDTH(TIMER_WIDTH)) u_props (
   .clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .protect_start_byte_in(protect_start_byte_in), .pump_on_out(pump_on_out), .hv_array_out(hv_array_out),
   .program_mode_out(program_mode_out), .erase_mode_out(erase_mode_out), .mass_mode_out(mass_mode_out),
   .erase_base_out(erase_base_out), .array_wr_out(array_wr_out), .array_addr_out(array_addr_out),
   .array_data_out(array_data_out), .read_ready_out(read_ready_out));

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
   typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} fpec_note_type;
   logic        clk_in, reset_n_in, avs_read_in, avs_write_in, avs_waitrequest_out;
   logic [3:0]  avs_address_in, avs_byteenable_in;
   logic [31:0] avs_writedata_in, avs_readdata_out;
   logic [7:0]  protect_start_byte_in, array_data_out;
   logic        pump_on_out, hv_array_out, program_mode_out, erase_mode_out, mass_mode_out;
   logic [15:0] erase_base_out, array_addr_out;
   logic        array_wr_out, read_ready_out;
   fpec_note_type notes_q[$];
   int          error_cnt = 0;
   int          compares = 0;
   // protection cases: byte, target, whole-erase flag in ms_t
   logic [7:0]  pb_t [7] = '{8'h00, 8'hb9, 8'hb9, 8'hfe, 8'hff, 8'hff, 8'hfe};
   // case 5 is a whole erase whose dummy write lands on the protect byte
   logic [15:0] ad_t [7] = '{16'hee00, 16'hee00, 16'hee40, 16'hffd0, 16'hffd0, 16'hffbe, 16'hf000};
   logic [6:0]  ms_t = 7'h60;

   fpec_control #(.TIMER_WIDTH(8)) uut (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .protect_start_byte_in(protect_start_byte_in), .pump_on_out(pump_on_out), .hv_array_out(hv_array_out),
      .program_mode_out(program_mode_out), .erase_mode_out(erase_mode_out), .mass_mode_out(mass_mode_out),
      .erase_base_out(erase_base_out), .array_wr_out(array_wr_out), .array_addr_out(array_addr_out),
      .array_data_out(array_data_out), .read_ready_out(read_ready_out));

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   // oldest note is matched to each accepted read or forwarded array write
   always @(posedge clk_in) begin
      fpec_note_type n;
      if ((avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) || array_wr_out === 1'b1) begin
         if (notes_q.size() == 0) check("unexpected result", 32'h1, 32'h0);
         else begin
            n = notes_q.pop_front();
            if (array_wr_out === 1'b1) check(n.name, {8'h0, array_data_out, array_addr_out}, n.exp);
            else check(n.name, avs_readdata_out & n.mask, n.exp);
         end
      end
   end

   initial begin
      #1000000;
      check("watchdog", 32'h1, 32'h0);
      end_of_test();
   end

   // ------------------------------------------------------------
   // bus master
   // ------------------------------------------------------------
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_read_in <= !w;
      avs_write_in <= w;
      do begin
         @(posedge clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0);
      check("wait edges", n, 32'h2);
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clk_in);
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] mask, input string name);
      notes_q.push_back('{name, exp, mask});
      bus(a, 1'b0, 32'h0);
   endtask : rd

   task automatic awr(input logic [15:0] ad, input logic [7:0] dat, input logic fwd);
      if (fwd) notes_q.push_back('{"forwarded write", {8'h0, dat, ad}, 32'hffffffff});
      bus(fpec_pkg::ARRAY_OFS, 1'b1, {8'h0, dat, ad});
   endtask : awr

   // select, protect read, first array write, then setup delay of 100 cycles
   task automatic latch(input logic [3:0] ctl, input logic [7:0] pb, input logic [15:0] ad, input logic [7:0] dat);
      protect_start_byte_in <= pb;
      bus(fpec_pkg::CTRL_OFS, 1'b1, {28'h0, ctl});
      rd(fpec_pkg::PROT_OFS, {24'h0, pb}, 32'hff, "protect byte");
      awr(ad, dat, 1'b1);
      repeat (105) @(posedge clk_in);
   endtask : latch

   initial begin
      logic [15:0] row;
      logic [7:0]  dat;
      logic        blk;
      logic [3:0]  ctl;
      reset_n_in = 1'b0;
      avs_address_in = 4'h0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0;
      avs_byteenable_in = 4'hf;
      protect_start_byte_in = 8'hff;
      void'($urandom(32'hcfe5));
      repeat (8) @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(posedge clk_in);
      rd(fpec_pkg::CTRL_OFS, 32'h0, 32'hf, "control reset");
      rd(fpec_pkg::STAT_OFS, 32'h10, 32'h1f, "status reset");
      rd(4'h2, 32'h0, 32'hffffffff, "unmapped read");
      bus(fpec_pkg::CTRL_OFS, 1'b1, 32'h4);
      rd(fpec_pkg::CTRL_OFS, 32'h4, 32'hf, "mass select");
      $display("test registers done");
      bus(fpec_pkg::CTRL_OFS, 1'b1, 32'h1);
      bus(fpec_pkg::CTRL_OFS, 1'b1, 32'h3);
      rd(fpec_pkg::CTRL_OFS, 32'h1, 32'hf, "interlocked select");
      rd(fpec_pkg::STAT_OFS, 32'h8, 32'h8, "refused flag");
      bus(fpec_pkg::STAT_OFS, 1'b1, 32'h8);
      rd(fpec_pkg::STAT_OFS, 32'h0, 32'h8, "refused cleared");
      bus(fpec_pkg::CTRL_OFS, 1'b1, 32'h9);
      rd(fpec_pkg::CTRL_OFS, 32'h1, 32'hf, "early voltage");
      bus(fpec_pkg::CTRL_OFS, 1'b1, 32'h0);
      $display("test interlock done");
      row = 16'hee00 + 16'(($urandom % 128) * 32);
      dat = 8'($urandom);
      latch(4'h1, 8'hff, row, dat);
      rd(fpec_pkg::STAT_OFS, 32'h6, 32'h6, "latched and setup");
      bus(fpec_pkg::CTRL_OFS, 1'b1, 32'h9);
      rd(fpec_pkg::CTRL_OFS, 32'h9, 32'hf, "program voltage");
      check("program pins", {28'h0, hv_array_out, mass_mode_out, erase_mode_out, program_mode_out}, 32'h9);
      repeat (50) @(posedge clk_in);
      check("pump on", {31'h0, pump_on_out}, 32'h1);
      check("reads parked", {31'h0, read_ready_out}, 32'h0);
      awr(row + 16'h1f, ~dat, 1'b1);
      repeat (300) @(posedge clk_in);
      awr(row ^ 16'h0020, dat, 1'b0);
      repeat (300) @(posedge clk_in);
      bus(fpec_pkg::CTRL_OFS, 1'b1, 32'h8);
      repeat (50) @(posedge clk_in);
      bus(fpec_pkg::CTRL_OFS, 1'b1, 32'h0);
      check("pump off", {31'h0, pump_on_out}, 32'h0);
      repeat (14) @(posedge clk_in);
      check("reads back", {31'h0, read_ready_out}, 32'h1);
      $display("test program done");
      for (int i = 0; i < 7; i++) begin
         blk = pb_t[i] != 8'hff && (ms_t[i] || ad_t[i] >= {2'h3, pb_t[i], 6'h00});
         ctl = ms_t[i] ? 4'h6 : 4'h2;
         latch(ctl, pb_t[i], ad_t[i], dat);
         check("erase base", {16'h0, erase_base_out}, {16'h0, ad_t[i] & 16'hffc0});
         rd(fpec_pkg::STAT_OFS, {26'h0, pb_t[i] != 8'hff && ad_t[i] >= {2'h3, pb_t[i], 6'h00}, 5'h0},
            32'h20, "protected flag");
         bus(fpec_pkg::CTRL_OFS, 1'b1, {28'h0, ctl | 4'h8});
         rd(fpec_pkg::CTRL_OFS, {28'h0, blk ? ctl : ctl | 4'h8}, 32'hf, "erase voltage");
         check("mode pins", {28'h0, hv_array_out, mass_mode_out, erase_mode_out, program_mode_out},
               {28'h0, blk ? ctl : ctl | 4'h8});
         // erase hold is software timed and not policed by the block; kept short to bound the run
         bus(fpec_pkg::CTRL_OFS, 1'b1, 32'h8);
         repeat (ms_t[i] ? 1000 : 50) @(posedge clk_in);
         bus(fpec_pkg::CTRL_OFS, 1'b1, 32'h0);
         repeat (14) @(posedge clk_in);
      end
      $display("test protection done");
      end_of_test();
   end
endmodule : tb_top
